/* File: clock_source_gate_monitor_pkg.sv */
// Purpose: constants shared by the clock source, gate and monitor block
// Assumes: 32-bit Avalon-MM register access, one 20 MHz system clock
// Notes: offsets are byte addresses on the register bus
package clock_source_gate_monitor_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MON_WINDOW_NS = 10000;
	localparam int unsigned MON_WINDOW_CYC = MON_WINDOW_NS / CLK_PERIOD_NS;

	localparam logic [31:0] OFS_GATE_1 = 32'h4000_0030;
	localparam logic [31:0] OFS_GATE_2 = 32'h4000_0034;
	localparam logic [31:0] OFS_OSC_CTRL = 32'h4000_0040;
	localparam logic [31:0] OFS_CLK_SEL = 32'h4000_0044;
	localparam logic [31:0] OFS_MON_CTRL = 32'h4000_0048;

	// implemented gate bits; everything else is reserved and reads zero
	localparam logic [31:0] GATE_1_MASK = 32'h030f_0f10;
	localparam logic [31:0] GATE_2_MASK = 32'h00f3_0f33;
	localparam logic [31:0] GATE_1_RESET = 32'h0000_0000;
	localparam logic [31:0] GATE_2_RESET = 32'h0000_0101;

	localparam logic [7:0] OSC_CTRL_MASK = 8'h3f;
	localparam logic [7:0] OSC_CTRL_RESET = 8'h20;
	localparam int unsigned OSC_FIELDS = 3;
	localparam int unsigned OSC_ON_BIT = 1;
	localparam int unsigned OSC_HALF_BIT = 0;

	localparam logic [7:0] CLK_SEL_MASK = 8'h07;
	localparam logic [7:0] CLK_SEL_RESET = 8'h00;
	localparam int unsigned PLL_IN_SEL_BIT = 2;
	localparam logic [1:0] MAIN_SEL_RING = 2'h0;
	localparam logic [1:0] MAIN_SEL_BYPASS = 2'h2;
	localparam logic [1:0] MAIN_SEL_PLL = 2'h3;

	localparam logic [15:0] MON_CTRL_RESET = 16'h0093;
	localparam int unsigned MON_REC_DIS_BIT = 15;
	localparam int unsigned MON_MAIN_EN_BIT = 7;
	localparam int unsigned MON_MAIN_IE_BIT = 6;
	localparam int unsigned MON_MAIN_FAIL_BIT = 5;
	localparam int unsigned MON_MAIN_PRES_BIT = 4;
	localparam int unsigned MON_XTAL_EN_BIT = 3;
	localparam int unsigned MON_XTAL_IE_BIT = 2;
	localparam int unsigned MON_XTAL_FAIL_BIT = 1;
	localparam int unsigned MON_XTAL_PRES_BIT = 0;

	// monitor channel numbering
	localparam int unsigned MON_XTAL = 0;
	localparam int unsigned MON_MAIN = 1;
	localparam int unsigned MON_CHANNELS = 2;
endpackage

/* File: clock_source_gate_monitor.sv */
// Purpose: peripheral clock gates, oscillator controls, clock selects and clock monitors
// Assumes: sense inputs are slow toggling copies of the watched clocks, asynchronous to CLK
// Notes:
// Notes on behaviour
// - a peripheral gate stays off until software writes one to its bit, except gate two bits 8 and 0, which reset on
// - writing zero to a gate bit stops that peripheral's clock enable
// - gate register one: timers 25,24,19-16, ports 11-8, DMA 4, low nibble reserved
// - gate register two: front end, converters, PWM, UARTs, I2C, SPI; bits 8,0 reset one
// - source control: ring 5:4 resets 10, internal 3:2, crystal 1:0; 0X off, 1X on
// - crystal field: 0X stops crystal, 10 runs it, 11 runs it halved
// - main select 0X ring, 10 PLL bypass, 11 PLL output; resets to 00
// - presence bits are only meaningful once their monitor enable is set
// - crystal monitor checks oscillation only, not frequency stability
// - main clock failure forces ring oscillator unless recovery disable bit set
// - main fail flag bit 5 sets on failure, write one clears; enable bit 6
// - crystal fail flag bit 1 sets on failure, write one clears; enable bit 2
// - bit 4 shows main clock present, bit 0 shows crystal oscillating
// - monitor register resets to bits 7, 4, 1 and 0 set, others zero
// - PLL input select chooses the clock feeding PLL and its bypass path
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module clock_source_gate_monitor
	import clock_source_gate_monitor_pkg::*;
#(
	parameter int unsigned MON_WINDOW = MON_WINDOW_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [31:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic MAIN_CLK_SENSE,
	input wire logic XTAL_SENSE,
	output logic [31:0] PERIPH_GATE_1,
	output logic [31:0] PERIPH_GATE_2,
	output logic RING_OSC_ON,
	output logic RING_OSC_HALF,
	output logic INT_OSC_ON,
	output logic INT_OSC_HALF,
	output logic XTAL_OSC_ON,
	output logic XTAL_OSC_HALF,
	output logic PLL_INPUT_SELECT,
	output logic [1:0] MAIN_CLOCK_SELECT,
	output logic IRQ_MAIN_FAIL,
	output logic IRQ_CRYSTAL_FAIL,
	output logic IRQ
);
	localparam int unsigned CW = $clog2(MON_WINDOW + 1);
	localparam logic [CW-1:0] WIN_LAST = CW'(MON_WINDOW - 1);

	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [31:0] be_mask;
	logic [31:0] wdata;
	logic wr_go;
	logic rd_go;
	logic sel_gate_1;
	logic sel_gate_2;
	logic sel_osc;
	logic sel_clk;
	logic sel_mon;
	logic [31:0] gate_1_ff;
	logic [31:0] gate_2_ff;
	logic [7:0] osc_ff;
	logic [7:0] clk_sel_ff;
	// monitor register kept as separate flops, one owner each, assembled only for reads
	logic rec_dis_ff;
	logic main_en_ff;
	logic main_ie_ff;
	logic xtal_en_ff;
	logic xtal_ie_ff;
	logic main_fail_ff;
	logic xtal_fail_ff;
	logic [15:0] mon_word;
	logic [31:0] nxt_rdata;
	logic [MON_CHANNELS-1:0] mon_en;
	logic [MON_CHANNELS-1:0] present;
	logic [MON_CHANNELS-1:0] fail_evt;
	logic [MON_CHANNELS-1:0] fail_clr;

	// bus slave: one wait state on every access, answer on the second edge
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
	assign wr_go = AVS_WRITE & ack_ff;
	assign rd_go = AVS_READ & ~ack_ff;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
		end
	end

	always_comb begin
		sel_gate_1 = 1'b0;
		sel_gate_2 = 1'b0;
		sel_osc = 1'b0;
		sel_clk = 1'b0;
		sel_mon = 1'b0;
		if (AVS_ADDRESS == OFS_GATE_1) begin
			sel_gate_1 = 1'b1;
		end else if (AVS_ADDRESS == OFS_GATE_2) begin
			sel_gate_2 = 1'b1;
		end else if (AVS_ADDRESS == OFS_OSC_CTRL) begin
			sel_osc = 1'b1;
		end else if (AVS_ADDRESS == OFS_CLK_SEL) begin
			sel_clk = 1'b1;
		end else if (AVS_ADDRESS == OFS_MON_CTRL) begin
			sel_mon = 1'b1;
		end
	end

	// byte lanes not enabled keep their old contents
	assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	assign wdata = AVS_WRITEDATA & be_mask;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			gate_1_ff <= GATE_1_RESET;
		end else if (wr_go && sel_gate_1) begin
			gate_1_ff <= ((gate_1_ff & ~be_mask) | wdata) & GATE_1_MASK;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			gate_2_ff <= GATE_2_RESET;
		end else if (wr_go && sel_gate_2) begin
			gate_2_ff <= ((gate_2_ff & ~be_mask) | wdata) & GATE_2_MASK;
		end
	end

	// gated peripherals see a registered enable, glitch free by construction
	assign PERIPH_GATE_1 = gate_1_ff;
	assign PERIPH_GATE_2 = gate_2_ff;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			osc_ff <= OSC_CTRL_RESET;
		end else if (wr_go && sel_osc && AVS_BYTEENABLE[0]) begin
			osc_ff <= AVS_WRITEDATA[7:0] & OSC_CTRL_MASK;
		end
	end

	// one decoder per source field: upper bit runs it, lower bit halves it
	logic [OSC_FIELDS-1:0] osc_on;
	logic [OSC_FIELDS-1:0] osc_half;
	genvar gi;
	generate
		for (gi = 0; gi < OSC_FIELDS; gi++) begin : g_osc
			assign osc_on[gi] = osc_ff[2*gi+OSC_ON_BIT];
			assign osc_half[gi] = osc_ff[2*gi+OSC_ON_BIT] & osc_ff[2*gi+OSC_HALF_BIT];
		end
	endgenerate

	assign XTAL_OSC_ON = osc_on[0];
	assign XTAL_OSC_HALF = osc_half[0];
	assign INT_OSC_ON = osc_on[1];
	assign INT_OSC_HALF = osc_half[1];
	assign RING_OSC_ON = osc_on[2];
	assign RING_OSC_HALF = osc_half[2];

	// recovery write wins over a software write in the same cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			clk_sel_ff <= CLK_SEL_RESET;
		end else begin
			if (wr_go && sel_clk && AVS_BYTEENABLE[0]) begin
				clk_sel_ff <= AVS_WRITEDATA[7:0] & CLK_SEL_MASK;
			end
			if (fail_evt[MON_MAIN] && !rec_dis_ff) begin
				clk_sel_ff[1:0] <= MAIN_SEL_RING;
			end
		end
	end

	// mux itself sits in the clock tree; only the steering lives here
	assign PLL_INPUT_SELECT = clk_sel_ff[PLL_IN_SEL_BIT];
	assign MAIN_CLOCK_SELECT = clk_sel_ff[1:0];

	// monitors: no edge on the sense input for a full window means absent
	logic [MON_CHANNELS-1:0] sense_in;
	assign sense_in[MON_XTAL] = XTAL_SENSE;
	assign sense_in[MON_MAIN] = MAIN_CLK_SENSE;
	assign mon_en[MON_XTAL] = xtal_en_ff;
	assign mon_en[MON_MAIN] = main_en_ff;

	generate
		for (gi = 0; gi < MON_CHANNELS; gi++) begin : g_mon
			logic sense_meta_ff;
			logic sense_sync_ff;
			logic sense_prev_ff;
			logic present_ff;
			logic [CW-1:0] idle_cnt_ff;
			logic edge_seen;
			logic timeout;

			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					sense_meta_ff <= 1'b0;
					sense_sync_ff <= 1'b0;
					sense_prev_ff <= 1'b0;
				end else begin
					sense_meta_ff <= sense_in[gi];
					sense_sync_ff <= sense_meta_ff;
					sense_prev_ff <= sense_sync_ff;
				end
			end

			// only activity is judged, never the frequency
			assign edge_seen = sense_sync_ff ^ sense_prev_ff;
			assign timeout = (idle_cnt_ff == WIN_LAST) & ~edge_seen;

			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					idle_cnt_ff <= '0;
				end else if (!mon_en[gi] || edge_seen) begin
					idle_cnt_ff <= '0;
				end else if (idle_cnt_ff != WIN_LAST) begin
					idle_cnt_ff <= idle_cnt_ff + 1'b1;
				end
			end

			// while disabled the bit freezes, so it is stale until enabled
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					present_ff <= 1'b1;
				end else if (mon_en[gi]) begin
					if (edge_seen) begin
						present_ff <= 1'b1;
					end else if (timeout) begin
						present_ff <= 1'b0;
					end
				end
			end

			assign present[gi] = present_ff;
			assign fail_evt[gi] = mon_en[gi] & present_ff & timeout;
		end
	endgenerate

	assign fail_clr[MON_XTAL] = wr_go & sel_mon & AVS_BYTEENABLE[0] &
		AVS_WRITEDATA[MON_XTAL_FAIL_BIT];
	assign fail_clr[MON_MAIN] = wr_go & sel_mon & AVS_BYTEENABLE[0] &
		AVS_WRITEDATA[MON_MAIN_FAIL_BIT];

	// control bits of the monitor register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rec_dis_ff <= MON_CTRL_RESET[MON_REC_DIS_BIT];
		end else if (wr_go && sel_mon && AVS_BYTEENABLE[1]) begin
			rec_dis_ff <= AVS_WRITEDATA[MON_REC_DIS_BIT];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			main_en_ff <= MON_CTRL_RESET[MON_MAIN_EN_BIT];
			main_ie_ff <= MON_CTRL_RESET[MON_MAIN_IE_BIT];
			xtal_en_ff <= MON_CTRL_RESET[MON_XTAL_EN_BIT];
			xtal_ie_ff <= MON_CTRL_RESET[MON_XTAL_IE_BIT];
		end else if (wr_go && sel_mon && AVS_BYTEENABLE[0]) begin
			main_en_ff <= AVS_WRITEDATA[MON_MAIN_EN_BIT];
			main_ie_ff <= AVS_WRITEDATA[MON_MAIN_IE_BIT];
			xtal_en_ff <= AVS_WRITEDATA[MON_XTAL_EN_BIT];
			xtal_ie_ff <= AVS_WRITEDATA[MON_XTAL_IE_BIT];
		end
	end

	// sticky fail flags: a new failure beats a same-cycle clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			main_fail_ff <= MON_CTRL_RESET[MON_MAIN_FAIL_BIT];
		end else if (fail_evt[MON_MAIN]) begin
			main_fail_ff <= 1'b1;
		end else if (fail_clr[MON_MAIN]) begin
			main_fail_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			xtal_fail_ff <= MON_CTRL_RESET[MON_XTAL_FAIL_BIT];
		end else if (fail_evt[MON_XTAL]) begin
			xtal_fail_ff <= 1'b1;
		end else if (fail_clr[MON_XTAL]) begin
			xtal_fail_ff <= 1'b0;
		end
	end

	// presence bits are the monitors' own state, read only
	// bits 14:8 have no storage and read zero
	always_comb begin
		mon_word = '0;
		mon_word[MON_REC_DIS_BIT] = rec_dis_ff;
		mon_word[MON_MAIN_EN_BIT] = main_en_ff;
		mon_word[MON_MAIN_IE_BIT] = main_ie_ff;
		mon_word[MON_MAIN_FAIL_BIT] = main_fail_ff;
		mon_word[MON_MAIN_PRES_BIT] = present[MON_MAIN];
		mon_word[MON_XTAL_EN_BIT] = xtal_en_ff;
		mon_word[MON_XTAL_IE_BIT] = xtal_ie_ff;
		mon_word[MON_XTAL_FAIL_BIT] = xtal_fail_ff;
		mon_word[MON_XTAL_PRES_BIT] = present[MON_XTAL];
	end

	assign IRQ_MAIN_FAIL = main_fail_ff & main_ie_ff;
	assign IRQ_CRYSTAL_FAIL = xtal_fail_ff & xtal_ie_ff;
	assign IRQ = IRQ_MAIN_FAIL | IRQ_CRYSTAL_FAIL;

	// read data is captured in the wait cycle and stands at the answer edge
	always_comb begin
		nxt_rdata = '0;
		if (sel_gate_1) begin
			nxt_rdata = gate_1_ff;
		end else if (sel_gate_2) begin
			nxt_rdata = gate_2_ff;
		end else if (sel_osc) begin
			nxt_rdata = {24'h00_0000, osc_ff};
		end else if (sel_clk) begin
			nxt_rdata = {24'h00_0000, clk_sel_ff};
		end else if (sel_mon) begin
			nxt_rdata = {16'h0000, mon_word};
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_ff <= '0;
		end else if (rd_go) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign AVS_READDATA = rdata_ff;
endmodule
`default_nettype wire

/* File: clock_source_gate_monitor_props.sv */
// Purpose: port-level checks for the clock source, gate and monitor block
// Assumes: full byte enables on every register access
// Notes: bound to the top module below the checker
`timescale 1ns/1ps
`default_nettype none
module csgm_checker
	import clock_source_gate_monitor_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [31:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic [31:0] PERIPH_GATE_1,
	input wire logic [31:0] PERIPH_GATE_2,
	input wire logic RING_OSC_ON,
	input wire logic XTAL_OSC_ON,
	input wire logic XTAL_OSC_HALF,
	input wire logic PLL_INPUT_SELECT,
	input wire logic [1:0] MAIN_CLOCK_SELECT,
	input wire logic IRQ_MAIN_FAIL,
	input wire logic IRQ_CRYSTAL_FAIL,
	input wire logic IRQ
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic wr_ok;
	assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
	wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE)
		|-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait not one cycle");
	gate_one_a: assert property (wr_ok && AVS_ADDRESS == OFS_GATE_1
		|=> PERIPH_GATE_1 == ($past(AVS_WRITEDATA) & GATE_1_MASK)) else $error("gate one");
	gate_two_a: assert property (wr_ok && AVS_ADDRESS == OFS_GATE_2
		|=> PERIPH_GATE_2 == ($past(AVS_WRITEDATA) & GATE_2_MASK)) else $error("gate two");
	gate_hold_a: assert property (!(wr_ok && AVS_ADDRESS == OFS_GATE_1)
		|=> $stable(PERIPH_GATE_1)) else $error("gate moved without write");
	rd_gate_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_GATE_1
		|-> AVS_READDATA == PERIPH_GATE_1) else $error("gate readback");
	osc_field_a: assert property (wr_ok && AVS_ADDRESS == OFS_OSC_CTRL
		|=> XTAL_OSC_ON == $past(AVS_WRITEDATA[1]) && XTAL_OSC_HALF == &$past(AVS_WRITEDATA[1:0])
		&& RING_OSC_ON == $past(AVS_WRITEDATA[5])) else $error("osc field");
	sel_write_a: assert property (wr_ok && AVS_ADDRESS == OFS_CLK_SEL
		|=> {PLL_INPUT_SELECT, MAIN_CLOCK_SELECT} == $past(AVS_WRITEDATA[2:0]))
		else $error("clock select");
	rst_val_a: assert property ($fell(RST) |-> PERIPH_GATE_1 == GATE_1_RESET
		&& PERIPH_GATE_2 == GATE_2_RESET && RING_OSC_ON && !XTAL_OSC_ON
		&& MAIN_CLOCK_SELECT == MAIN_SEL_RING) else $error("reset value");
	irq_or_a: assert property (IRQ == (IRQ_MAIN_FAIL || IRQ_CRYSTAL_FAIL))
		else $error("irq not the or");
	main_clr_a: assert property ($fell(IRQ_MAIN_FAIL)
		|-> $past(wr_ok && AVS_ADDRESS == OFS_MON_CTRL)) else $error("irq fell alone");
endmodule
bind clock_source_gate_monitor csgm_checker u_chk (.CLK, .RST, .AVS_ADDRESS, .AVS_READ,
	.AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .PERIPH_GATE_1,
	.PERIPH_GATE_2, .RING_OSC_ON, .XTAL_OSC_ON, .XTAL_OSC_HALF, .PLL_INPUT_SELECT,
	.MAIN_CLOCK_SELECT, .IRQ_MAIN_FAIL, .IRQ_CRYSTAL_FAIL, .IRQ);
`default_nettype wire

/* File: clk_sense_src.sv */
// Purpose: stand-in for a watched clock seen through its slow sense copy
// Assumes: toggles well below half the system clock rate
// Notes: a stopped clock holds its last level, as a dead oscillator would
`timescale 1ns/1ps
`default_nettype none
module clk_sense_src #(
	parameter int HALF = 4
) (
	input wire logic CLK,
	input wire logic run,
	output logic sense
);
	int cnt = 0;
	initial sense = 1'b0;
	always @(posedge CLK) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) sense <= ~sense;
		end
	end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench for the clock source, gate and monitor block
// Assumes: short monitor window so failures show within a few dozen cycles
// Notes: register model kept in mdl, compared on every register read and port check
`timescale 1ns/1ps
`default_nettype none
module tb;
	import clock_source_gate_monitor_pkg::*;
	logic CLK = 1'b0;
	logic RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, mrun, xrun, MAIN_CLK_SENSE, XTAL_SENSE;
	logic [31:0] AVS_ADDRESS, AVS_WRITEDATA, AVS_READDATA, PERIPH_GATE_1, PERIPH_GATE_2, rdv;
	logic [31:0] seed;
	logic [3:0] AVS_BYTEENABLE;
	logic RING_OSC_ON, RING_OSC_HALF, INT_OSC_ON, INT_OSC_HALF, XTAL_OSC_ON, XTAL_OSC_HALF;
	logic PLL_INPUT_SELECT, IRQ_MAIN_FAIL, IRQ_CRYSTAL_FAIL, IRQ;
	logic [1:0] MAIN_CLOCK_SELECT;
	logic [31:0] mdl [5];
	logic [31:0] adr [5] = '{OFS_GATE_1, OFS_GATE_2, OFS_OSC_CTRL, OFS_CLK_SEL, OFS_MON_CTRL};
	logic [31:0] msk [5] = '{GATE_1_MASK, GATE_2_MASK, {24'h0, OSC_CTRL_MASK},
		{24'h0, CLK_SEL_MASK}, 32'h80dd};
	int err_total = 0;
	int samples_checked = 0;
	int i;
	always #25 CLK = ~CLK;
	clock_source_gate_monitor #(.MON_WINDOW(16)) u_dut (.CLK, .RST, .AVS_ADDRESS, .AVS_READ,
		.AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
		.MAIN_CLK_SENSE, .XTAL_SENSE, .PERIPH_GATE_1, .PERIPH_GATE_2, .RING_OSC_ON,
		.RING_OSC_HALF, .INT_OSC_ON, .INT_OSC_HALF, .XTAL_OSC_ON, .XTAL_OSC_HALF,
		.PLL_INPUT_SELECT, .MAIN_CLOCK_SELECT, .IRQ_MAIN_FAIL, .IRQ_CRYSTAL_FAIL, .IRQ);
	clk_sense_src #(.HALF(4)) u_msrc (.CLK, .run(mrun), .sense(MAIN_CLK_SENSE));
	clk_sense_src #(.HALF(3)) u_xsrc (.CLK, .run(xrun), .sense(XTAL_SENSE));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// waits are bounded; running out ends the run as a failure
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			err_total++;
			end_of_test();
		end
	endtask
	// looked at on the rising edge before its updates land: the same values the design samples
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0 && n < 40) begin
			@(posedge CLK);
			n++;
		end
		tmo(n, 40);
		rdv = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input int r, input logic [31:0] d);
		bus(1'b1, adr[r], d);
		if (r == 4) mdl[4] = (d & 32'h80cc) | (mdl[4] & 32'h11) | (mdl[4] & ~d & 32'h22);
		else mdl[r] = d & msk[r];
	endtask
	task automatic rdc(input int r);
		bus(1'b0, adr[r], 32'h0);
		chk("register", mdl[r], rdv);
	endtask
	task automatic ports;
		logic [7:0] o;
		logic [15:0] m;
		o = mdl[2][7:0];
		m = mdl[4][15:0];
		chk("gate one", mdl[0], PERIPH_GATE_1);
		chk("gate two", mdl[1], PERIPH_GATE_2);
		chk("osc", {o[5], &o[5:4], o[3], &o[3:2], o[1], &o[1:0]}, {RING_OSC_ON, RING_OSC_HALF, INT_OSC_ON, INT_OSC_HALF, XTAL_OSC_ON, XTAL_OSC_HALF});
		chk("select", mdl[3][2:0], {PLL_INPUT_SELECT, MAIN_CLOCK_SELECT});
		chk("irq", {m[5] & m[6], m[1] & m[2], |(m & 16'h0066) && (m[5] & m[6] || m[1] & m[2])}, {IRQ_MAIN_FAIL, IRQ_CRYSTAL_FAIL, IRQ});
	endtask
	task automatic wt(input logic main);
		int n;
		n = 0;
		while ((main ? IRQ_MAIN_FAIL : IRQ_CRYSTAL_FAIL) !== 1'b1 && n < 200) begin
			@(posedge CLK);
			n++;
		end
		tmo(n, 200);
	endtask
	initial begin
		RST = 1'b1;
		{AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
		AVS_BYTEENABLE = 4'hf;
		mrun = 1'b1;
		xrun = 1'b1;
		seed = 32'h0001_1cf4;
		mdl = '{GATE_1_RESET, GATE_2_RESET, {24'h0, OSC_CTRL_RESET}, {24'h0, CLK_SEL_RESET},
			{16'h0, MON_CTRL_RESET}};
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		for (i = 0; i < 5; i++) rdc(i);
		ports();
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(i % 2, seed);
			rdc(i % 2);
			ports();
		end
		wr(0, 32'h0);
		wr(1, 32'h0);
		ports();
		for (i = 0; i < 4; i++) begin
			wr(2, {26'h0, i[1:0], i[1:0], i[1:0]});
			rdc(2);
			ports();
		end
		wr(2, 32'h2a);
		for (i = 0; i < 8; i++) begin
			wr(3, 32'(i));
			rdc(3);
			ports();
		end
		bus(1'b1, 32'h4000_0038, 32'hffff_ffff);
		bus(1'b0, 32'h4000_0038, 32'h0);
		chk("unmapped", 32'h0, rdv);
		for (i = 0; i < 5; i++) rdc(i);
		wr(4, 32'h00ee);
		rdc(4);
		xrun <= 1'b0;
		wt(1'b0);
		mdl[4] = (mdl[4] & ~32'h1) | 32'h2;
		rdc(4);
		ports();
		wr(4, 32'h00ee);
		rdc(4);
		wr(3, 32'h7);
		mrun <= 1'b0;
		wt(1'b1);
		mdl[4] = (mdl[4] & ~32'h10) | 32'h20;
		mdl[3] = mdl[3] & 32'h4;
		rdc(4);
		ports();
		mrun <= 1'b1;
		repeat (12) @(posedge CLK);
		mdl[4] = mdl[4] | 32'h10;
		wr(4, 32'h808e);
		rdc(4);
		ports();
		wr(4, 32'h80ec);
		wr(3, 32'h7);
		mrun <= 1'b0;
		wt(1'b1);
		mdl[4] = (mdl[4] & ~32'h10) | 32'h20;
		rdc(3);
		rdc(4);
		ports();
		end_of_test();
	end
endmodule
`default_nettype wire
